// file: logic/shift_store_pkg.sv
`default_nettype none

package shift_store_pkg;

    // register width and cleared value
    localparam int unsigned WORD_WIDTH = 8;
    localparam logic [WORD_WIDTH-1:0] WORD_CLEAR = 8'h00;

    // end bit positions used by the serial ports
    localparam int unsigned LOW_END_BIT = 0;
    localparam int unsigned HIGH_END_BIT = WORD_WIDTH - 1;

    // mode encodings, written as {mode_select_hi, mode_select_lo}
    localparam logic [1:0] MODE_HOLD = 2'h0;
    localparam logic [1:0] MODE_SHIFT_RIGHT = 2'h1;
    localparam logic [1:0] MODE_SHIFT_LEFT = 2'h2;
    localparam logic [1:0] MODE_LOAD = 2'h3;

    // sampled clock pin level after reset; high blocks a false first edge
    localparam logic CLOCK_PIN_RESET = 1'h1;

    // driver enable levels
    localparam logic DRIVE_ON = 1'h1;
    localparam logic DRIVE_OFF = 1'h0;

endpackage

`default_nettype wire

// file: logic/line_driver.sv
`default_nettype none

module line_driver #(
    parameter int unsigned WIDTH = shift_store_pkg::WORD_WIDTH
) (
    input wire logic [WIDTH-1:0] word,
    input wire logic enable_a_n,
    input wire logic enable_b_n,
    input wire logic load_mode,
    output logic [WIDTH-1:0] line_o,
    output logic [WIDTH-1:0] line_oe
);

    logic drive;

    always_comb
    begin
        // either enable high, or load mode, releases the lines
        if (enable_a_n || enable_b_n || load_mode)
        begin
            drive = shift_store_pkg::DRIVE_OFF;
        end
        else
        begin
            drive = shift_store_pkg::DRIVE_ON;
        end
    end

    assign line_o = word;
    assign line_oe = {WIDTH{drive}};

endmodule

`default_nettype wire

// file: logic/universal_shift_storage_register.sv
`default_nettype none

module universal_shift_storage_register #(
    parameter int unsigned WIDTH = shift_store_pkg::WORD_WIDTH
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic clear_n,
    input wire logic shift_clock,
    input wire logic mode_select_lo,
    input wire logic mode_select_hi,
    input wire logic right_shift_serial_in,
    input wire logic left_shift_serial_in,
    input wire logic output_enable_a_n,
    input wire logic output_enable_b_n,
    input wire logic [WIDTH-1:0] shared_parallel_lines_i,
    output logic [WIDTH-1:0] shared_parallel_lines_o,
    output logic [WIDTH-1:0] shared_parallel_lines_oe,
    output logic low_end_serial_out,
    output logic high_end_serial_out
);

    ////////////////////////////////////////////////////////////////////////
    // functions

    // mode decode, shared by the datapath and the checks
    function automatic logic [1:0] mode_of(
        input logic sel_hi,
        input logic sel_lo
    );
        mode_of = {sel_hi, sel_lo};
    endfunction

    // next register word for a given mode
    function automatic logic [WIDTH-1:0] next_word(
        input logic [1:0] mode,
        input logic [WIDTH-1:0] word,
        input logic [WIDTH-1:0] lines,
        input logic ser_right,
        input logic ser_left
    );
        unique case (mode)
            shift_store_pkg::MODE_HOLD:
            begin
                next_word = word;
            end
            shift_store_pkg::MODE_SHIFT_RIGHT:
            begin
                next_word = {word[WIDTH-2:0], ser_right};
            end
            shift_store_pkg::MODE_SHIFT_LEFT:
            begin
                next_word = {ser_left, word[WIDTH-1:1]};
            end
            shift_store_pkg::MODE_LOAD:
            begin
                next_word = lines;
            end
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // clock pin edge detect

    logic clock_pin_q;
    logic clock_pin_d;
    logic shift_edge;

    always_comb
    begin
        clock_pin_d = clock_pin_q;
        if (clk_en)
        begin
            clock_pin_d = shift_clock;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            clock_pin_q <= shift_store_pkg::CLOCK_PIN_RESET;
        end
        else
        begin
            clock_pin_q <= clock_pin_d;
        end
    end

    // only a low-to-high step of the clock pin advances the register
    assign shift_edge = clk_en && shift_clock && !clock_pin_q;

    ////////////////////////////////////////////////////////////////////////
    // storage register

    logic [WIDTH-1:0] word_q;
    logic [WIDTH-1:0] word_d;
    logic [1:0] mode;

    assign mode = mode_of(mode_select_hi, mode_select_lo);

    always_comb
    begin
        word_d = word_q;
        if (shift_edge)
        begin
            word_d = next_word(mode, word_q, shared_parallel_lines_i,
                right_shift_serial_in, left_shift_serial_in);
        end
    end

    // clear acts at once, without the clock; it loads only a constant
    always_ff @(posedge mclk or negedge clear_n)
    begin
        if (!clear_n)
        begin
            word_q <= shift_store_pkg::WORD_CLEAR;
        end
        else if (!resetn)
        begin
            word_q <= shift_store_pkg::WORD_CLEAR;
        end
        else
        begin
            word_q <= word_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    // end bits are plain outputs, never released
    assign low_end_serial_out = word_q[shift_store_pkg::LOW_END_BIT];
    assign high_end_serial_out = word_q[shift_store_pkg::HIGH_END_BIT];

    line_driver #(
        .WIDTH(WIDTH)
    ) u_line_driver (
        .word(word_q),
        .enable_a_n(output_enable_a_n),
        .enable_b_n(output_enable_b_n),
        .load_mode(mode == shift_store_pkg::MODE_LOAD),
        .line_o(shared_parallel_lines_o),
        .line_oe(shared_parallel_lines_oe)
    );

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge mclk);
    endclocking

    default disable iff (!resetn || !clear_n);

    logic released;
    assign released = output_enable_a_n || output_enable_b_n;

    sequence edge_in(logic [1:0] m);
        shift_edge && mode == m;
    endsequence

    a_hold_keeps: assert property (
        edge_in(shift_store_pkg::MODE_HOLD) |=> word_q == $past(word_q)
    )
    else $error("hold mode changed the register");

    a_shift_right: assert property (
        edge_in(shift_store_pkg::MODE_SHIFT_RIGHT) |=>
            word_q == {$past(word_q[WIDTH-2:0]),
                $past(right_shift_serial_in)}
    )
    else $error("shift right result wrong");

    a_shift_left: assert property (
        edge_in(shift_store_pkg::MODE_SHIFT_LEFT) |=>
            word_q == {$past(left_shift_serial_in),
                $past(word_q[WIDTH-1:1])}
    )
    else $error("shift left result wrong");

    a_load_copies: assert property (
        edge_in(shift_store_pkg::MODE_LOAD) |=>
            word_q == $past(shared_parallel_lines_i)
    )
    else $error("parallel load did not copy the lines");

    a_no_edge_stable: assert property (
        !shift_edge |=> $stable(word_q)
    )
    else $error("register changed without a clock edge");

    a_edge_single: assert property (
        shift_edge |=> !shift_edge
    )
    else $error("one clock pin rise gave two advances");

    a_enable_release: assert property (
        released |-> shared_parallel_lines_oe == '0
    )
    else $error("lines driven while an enable is high");

    a_load_release: assert property (
        mode == shift_store_pkg::MODE_LOAD |-> shared_parallel_lines_oe == '0
    )
    else $error("lines driven in load mode");

    a_lines_driven: assert property (
        !released && mode != shift_store_pkg::MODE_LOAD |->
            shared_parallel_lines_oe == '1 &&
            shared_parallel_lines_o == word_q
    )
    else $error("enabled lines do not show the register");

    a_shift_released: assert property (
        released ##0 edge_in(shift_store_pkg::MODE_SHIFT_RIGHT) |=>
            word_q[shift_store_pkg::LOW_END_BIT] ==
            $past(right_shift_serial_in)
    )
    else $error("shift lost while lines released");

    a_end_outputs: assert property (
        low_end_serial_out == word_q[shift_store_pkg::LOW_END_BIT] &&
        high_end_serial_out == word_q[shift_store_pkg::HIGH_END_BIT]
    )
    else $error("end outputs do not follow bits zero and seven");

    a_clear_zero: assert property (
        @(posedge mclk) disable iff (!resetn)
        !clear_n |-> word_q == shift_store_pkg::WORD_CLEAR
    )
    else $error("register not zero while clear is low");

    a_freeze_cen: assert property (
        !clk_en |=> $stable(word_q) && $stable(clock_pin_q)
    )
    else $error("state moved while clock enable low");

    a_released_load: assert property (
        released ##0 edge_in(shift_store_pkg::MODE_LOAD) |=>
            word_q == $past(shared_parallel_lines_i)
    )
    else $error("load lost while lines released");

    a_released_left: assert property (
        released ##0 edge_in(shift_store_pkg::MODE_SHIFT_LEFT) |=>
            word_q[shift_store_pkg::HIGH_END_BIT] ==
            $past(left_shift_serial_in)
    )
    else $error("shift left lost while lines released");

    a_serial_right: assert property (
        edge_in(shift_store_pkg::MODE_SHIFT_RIGHT) |=>
            low_end_serial_out == $past(right_shift_serial_in)
    )
    else $error("low end output missed the shifted-in bit");

    // pin reset level must hide a pin already high at release
    a_reset_no_edge: assert property (
        !resetn |=> !shift_edge
    )
    else $error("false clock pin rise right after reset");

    a_reset_clears: assert property (
        @(posedge mclk) disable iff (!clear_n)
        !resetn |=> word_q == shift_store_pkg::WORD_CLEAR
    )
    else $error("reset left the register set");

    c_load_then_shift: cover property (
        edge_in(shift_store_pkg::MODE_LOAD) ##[1:8]
        edge_in(shift_store_pkg::MODE_SHIFT_RIGHT)
    );

    c_shift_left: cover property (
        edge_in(shift_store_pkg::MODE_SHIFT_LEFT) ##1
        high_end_serial_out
    );

    c_released_shift: cover property (
        released ##0 edge_in(shift_store_pkg::MODE_SHIFT_LEFT)
    );

    c_hold_edge: cover property (
        edge_in(shift_store_pkg::MODE_HOLD)
    );

    c_released_load: cover property (
        released ##0 edge_in(shift_store_pkg::MODE_LOAD)
    );

endmodule

`default_nettype wire

// file: bench/bus_partner.sv
`default_nettype none

// far side of the shared parallel lines
module bus_partner (
    input wire logic mclk,
    input wire logic [7:0] line_o,
    input wire logic [7:0] line_oe,
    input wire logic drive_en,
    input wire logic [7:0] drive_val,
    output logic [7:0] level,
    output logic clash
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] last_q;
    // bits driven by neither side flip every cycle so a stale value never passes
    assign level = (line_oe & line_o) |
        (~line_oe & (drive_en ? drive_val : ~last_q));
    assign clash = drive_en && (line_oe != 8'h00);
    always_ff @(posedge mclk)
    begin
        last_q <= level;
    end
endmodule

`default_nettype wire

// file: bench/tb.sv
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk = 1'h0;
    logic resetn = 1'h0;
    logic clk_en = 1'h1;
    logic clear_n = 1'h1;
    logic sclk = 1'h0;
    logic [1:0] mode = shift_store_pkg::MODE_HOLD;
    logic dsr = 1'h0;
    logic dsl = 1'h0;
    logic [1:0] oe_n = 2'h0;
    logic drv_en = 1'h0;
    logic [7:0] drv_val = 8'h00;
    logic [7:0] lv, lo, loe, exp_q;
    logic q_lo, q_hi, clash;
    int bad_count = 0;
    int n_checks = 0;
    always #12.5 mclk = ~mclk;
    universal_shift_storage_register dut (
        .mclk(mclk), .resetn(resetn), .clk_en(clk_en), .clear_n(clear_n),
        .shift_clock(sclk), .mode_select_lo(mode[0]),
        .mode_select_hi(mode[1]), .right_shift_serial_in(dsr),
        .left_shift_serial_in(dsl), .output_enable_a_n(oe_n[0]),
        .output_enable_b_n(oe_n[1]), .shared_parallel_lines_i(lv),
        .shared_parallel_lines_o(lo), .shared_parallel_lines_oe(loe),
        .low_end_serial_out(q_lo), .high_end_serial_out(q_hi));
    bus_partner far_end (.mclk(mclk), .line_o(lo), .line_oe(loe),
        .drive_en(drv_en), .drive_val(drv_val), .level(lv), .clash(clash));
    ////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [7:0] e,
        input logic [7:0] g);
        n_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cw(input string nm);
        chk(nm, exp_q, lo);
        chk("low end", {7'h00, exp_q[0]}, {7'h00, q_lo});
        chk("high end", {7'h00, exp_q[7]}, {7'h00, q_hi});
    endtask
    // one rise of the device clock pin with mode and serial data set
    task automatic adv(input logic [1:0] m, input logic r, input logic l);
        @(posedge mclk)
        begin
            mode <= m;
            dsr <= r;
            dsl <= l;
            sclk <= 1'h1;
        end
        @(posedge mclk) sclk <= 1'h0;
        #1;
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_load();
        @(posedge mclk)
        begin
            mode <= shift_store_pkg::MODE_LOAD;
            drv_en <= 1'h1;
            drv_val <= 8'hA5;
        end
        #1 chk("oe in load", 8'h00, loe);
        adv(shift_store_pkg::MODE_LOAD, 1'h0, 1'h0);
        exp_q = 8'hA5;
        cw("load");
        chk("clash", 8'h00, {7'h00, clash});
        @(posedge mclk)
        begin
            mode <= shift_store_pkg::MODE_HOLD;
            drv_en <= 1'h0;
        end
        #1 chk("oe driving", 8'hFF, loe);
        chk("bus level", 8'hA5, lv);
    endtask
    task automatic t_hold();
        adv(shift_store_pkg::MODE_HOLD, 1'h1, 1'h1);
        cw("hold");
        @(posedge mclk) mode <= shift_store_pkg::MODE_SHIFT_RIGHT;
        repeat (4) @(posedge mclk);
        #1 cw("no rise");
        @(posedge mclk) clk_en <= 1'h0;
        @(posedge mclk) sclk <= 1'h1;
        @(posedge mclk) sclk <= 1'h0;
        @(posedge mclk) clk_en <= 1'h1;
        #1 cw("frozen");
    endtask
    task automatic t_shift();
        for (int i = 0; i < 8; i++)
        begin
            adv(shift_store_pkg::MODE_SHIFT_RIGHT, i[0], 1'h0);
            exp_q = {exp_q[6:0], i[0]};
            cw("right");
        end
        for (int i = 0; i < 8; i++)
        begin
            adv(shift_store_pkg::MODE_SHIFT_LEFT, 1'h0, i[1]);
            exp_q = {i[1], exp_q[7:1]};
            cw("left");
        end
    endtask
    task automatic t_release();
        for (int k = 1; k < 4; k++)
        begin
            @(posedge mclk) oe_n <= k[1:0];
            #1 chk("oe released", 8'h00, loe);
            adv(shift_store_pkg::MODE_SHIFT_RIGHT, 1'h1, 1'h0);
            exp_q = {exp_q[6:0], 1'h1};
            cw("released shift");
        end
        @(posedge mclk)
        begin
            drv_en <= 1'h1;
            drv_val <= 8'h3C;
        end
        adv(shift_store_pkg::MODE_LOAD, 1'h0, 1'h0);
        exp_q = 8'h3C;
        cw("released load");
        adv(shift_store_pkg::MODE_SHIFT_LEFT, 1'h0, 1'h1);
        exp_q = {1'h1, exp_q[7:1]};
        cw("released left");
        @(posedge mclk)
        begin
            oe_n <= 2'h0;
            drv_en <= 1'h0;
        end
    endtask
    // reset in mid-run with the device clock pin already high
    task automatic t_reset();
        @(posedge mclk)
        begin
            resetn <= 1'h0;
            sclk <= 1'h1;
            mode <= shift_store_pkg::MODE_SHIFT_RIGHT;
            dsr <= 1'h1;
        end
        @(posedge mclk);
        @(posedge mclk) resetn <= 1'h1;
        #1 exp_q = shift_store_pkg::WORD_CLEAR;
        cw("mid reset");
        repeat (2) @(posedge mclk);
        #1 cw("pin high at release");
        @(posedge mclk) sclk <= 1'h0;
        adv(shift_store_pkg::MODE_SHIFT_RIGHT, 1'h1, 1'h0);
        exp_q = 8'h01;
        cw("first rise after reset");
    endtask
    task automatic t_clear();
        @(posedge mclk)
        begin
            clear_n <= 1'h0;
            mode <= shift_store_pkg::MODE_LOAD;
        end
        #1 exp_q = shift_store_pkg::WORD_CLEAR;
        cw("clear");
        @(posedge mclk) drv_en <= 1'h1;
        adv(shift_store_pkg::MODE_LOAD, 1'h0, 1'h0);
        cw("clear over load");
        @(posedge mclk)
        begin
            clear_n <= 1'h1;
            drv_en <= 1'h0;
        end
    endtask
    ////////////////////////////////////////////////////////////
    initial
    begin
        repeat (12) @(posedge mclk);
        resetn <= 1'h1;
        #1 exp_q = shift_store_pkg::WORD_CLEAR;
        cw("after reset");
        t_load();
        t_hold();
        t_shift();
        t_release();
        t_reset();
        t_clear();
        wrap_up();
    end
    initial
    begin
        repeat (4000) @(posedge mclk);
        bad_count++;
        wrap_up();
    end
endmodule

`default_nettype wire
